// file: hdl/rbe_engine.sv
// RAM self-test engine with its test control register
`timescale 1ns/1ps
module rbe_engine import rbe_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic test_pin,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output rbe_ram_req_type ram_req,
   input wire logic [63:0] ram_rdata,
   output logic [15:0] fail_addr,
   output logic full_ram_write_enable,
   output logic host_block
);
   logic tp_s1_q, tp_s1_d, tp_s2_q, tp_s2_d;
   logic fwe_q, fwe_d, force_q, force_d, go_q, go_d, pass_q, pass_d, fail_q, fail_d;
   logic [2:0] sel_q, sel_d, run_sel_q, run_sel_d;
   rbe_state_type st_q, st_d;
   rbe_phase_type ph_q, ph_d;
   logic [3:0] step_q, step_d;
   logic [12:0] addr_q, addr_d;
   logic [15:0] fail_addr_q, fail_addr_d;
   rbe_ram_req_type req_q, req_d;
   rbe_op_type op;
   logic [63:0] expect_data;
   logic mismatch;
   logic adv;

   function automatic rbe_phase_type first_phase(input logic [2:0] sel);
      unique case (sel)
         RBE_SEL_PATTERN, RBE_SEL_FILL0: first_phase = RBE_PH_FILL0;
         RBE_SEL_VER0: first_phase = RBE_PH_VER0;
         RBE_SEL_FILL1: first_phase = RBE_PH_FILL1;
         RBE_SEL_VER1: first_phase = RBE_PH_VER1;
         RBE_SEL_INCDEC: first_phase = RBE_PH_AWR;
         default: first_phase = RBE_PH_DONE;
      endcase
   endfunction

   function automatic rbe_phase_type next_phase(input rbe_phase_type ph, input logic [2:0] sel);
      unique case (ph)
         RBE_PH_FILL0: next_phase = (sel == RBE_SEL_PATTERN) ? RBE_PH_MARCH_UP : RBE_PH_DONE;
         RBE_PH_MARCH_UP: next_phase = RBE_PH_MARCH_DN;
         RBE_PH_MARCH_DN: next_phase = RBE_PH_AWR;
         RBE_PH_AWR: next_phase = RBE_PH_ARD;
         RBE_PH_ARD: next_phase = RBE_PH_CWR;
         RBE_PH_CWR: next_phase = RBE_PH_CRD;
         default: next_phase = RBE_PH_DONE;
      endcase
   endfunction

   function automatic rbe_op_type get_op(input rbe_phase_type ph, input logic [3:0] step);
      logic [2:0] idx;
      idx = 3'((step - 4'h1) >> 1);
      get_op = '{rd: 1'b0, kind: RBE_K_CONST, data: RBE_ZERO, last: 1'b1};
      unique case (ph)
         RBE_PH_FILL0: get_op.data = RBE_ZERO;
         RBE_PH_FILL1: get_op.data = RBE_ONES;
         RBE_PH_VER0: get_op.rd = 1'b1;
         RBE_PH_VER1: get_op = '{rd: 1'b1, kind: RBE_K_CONST, data: RBE_ONES, last: 1'b1};
         RBE_PH_AWR: get_op.kind = RBE_K_ADDR;
         RBE_PH_ARD: get_op = '{rd: 1'b1, kind: RBE_K_ADDR, data: RBE_ZERO, last: 1'b1};
         RBE_PH_CWR: get_op.kind = RBE_K_CPL;
         RBE_PH_CRD: get_op = '{rd: 1'b1, kind: RBE_K_CPL, data: RBE_ZERO, last: 1'b1};
         RBE_PH_MARCH_UP: begin
            get_op.rd = (step == RBE_STEP_FIRST) || !step[0];
            get_op.data = (step == RBE_STEP_FIRST) ? RBE_ZERO : RBE_PAT_UP[idx];
            get_op.last = (step == RBE_MARCH_LAST_STEP);
         end
         RBE_PH_MARCH_DN: begin
            get_op.rd = (step == RBE_STEP_FIRST) || !step[0];
            get_op.data = (step == RBE_STEP_FIRST) ? RBE_ONES : RBE_PAT_DN[idx];
            get_op.last = (step == RBE_MARCH_LAST_STEP);
         end
         default: get_op.rd = 1'b0;
      endcase
   endfunction

   assign op = get_op(ph_q, step_q);

   rbe_lane u_lane (
      .kind(op.kind),
      .data(op.data),
      .addr(addr_q),
      .rdata(ram_rdata),
      .expect_data(expect_data),
      .mismatch(mismatch)
   );

   always_comb begin
      tp_s1_d = test_pin;
      tp_s2_d = tp_s1_q;
      fwe_d = fwe_q;
      force_d = force_q;
      sel_d = sel_q;
      go_d = go_q;
      pass_d = pass_q;
      fail_d = fail_q;
      run_sel_d = run_sel_q;
      st_d = st_q;
      ph_d = ph_q;
      step_d = step_q;
      addr_d = addr_q;
      fail_addr_d = fail_addr_q;
      req_d = '0;
      adv = 1'b0;
      if (reg_wr) begin
         fwe_d = reg_wdata[RBE_BIT_FWE];
         force_d = reg_wdata[RBE_BIT_FORCE];
         sel_d = reg_wdata[RBE_BIT_SEL_HI:RBE_BIT_SEL_LO];
         // gated by synchronised test pin and prior enable
         if (reg_wdata[RBE_BIT_GO] && tp_s2_q && fwe_q && (st_q == RBE_ST_IDLE)) begin
            go_d = 1'b1;
            pass_d = 1'b0;
            fail_d = 1'b0;
            run_sel_d = reg_wdata[RBE_BIT_SEL_HI:RBE_BIT_SEL_LO];
            ph_d = first_phase(reg_wdata[RBE_BIT_SEL_HI:RBE_BIT_SEL_LO]);
            addr_d = RBE_ADDR_FIRST;
            step_d = RBE_STEP_FIRST;
            st_d = RBE_ST_OP;
         end
      end
      unique case (st_q)
         RBE_ST_IDLE: adv = 1'b0;
         RBE_ST_OP: begin
            if (ph_q == RBE_PH_DONE) begin
               go_d = 1'b0;
               // forced failure overrides a clean run
               pass_d = !force_q;
               fail_d = force_q;
               st_d = RBE_ST_IDLE;
            end else begin
               req_d.addr = addr_q;
               // low words go to hidden RAM behind the registers
               req_d.hidden = (addr_q <= RBE_HIDDEN_TOP);
               req_d.we = !op.rd;
               req_d.re = op.rd;
               req_d.wdata = expect_data;
               if (op.rd) begin
                  st_d = RBE_ST_WAIT;
               end else begin
                  adv = 1'b1;
               end
            end
         end
         // Read data lags the registered request by one cycle
         RBE_ST_WAIT: st_d = RBE_ST_CHK;
         RBE_ST_CHK: begin
            if (mismatch || force_q) begin
               fail_d = 1'b1;
               go_d = 1'b0;
               fail_addr_d = {3'h0, addr_q};
               st_d = RBE_ST_IDLE;
            end else begin
               adv = 1'b1;
            end
         end
      endcase
      if (adv) begin
         st_d = RBE_ST_OP;
         if (op.last) begin
            step_d = RBE_STEP_FIRST;
            if (addr_q == RBE_ADDR_LAST) begin
               addr_d = RBE_ADDR_FIRST;
               ph_d = next_phase(ph_q, run_sel_q);
            end else begin
               addr_d = addr_q + 13'h0001;
            end
         end else begin
            step_d = step_q + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tp_s1_q <= 1'b0;
         tp_s2_q <= 1'b0;
         fwe_q <= RBE_CTRL_RESET[RBE_BIT_FWE];
         force_q <= RBE_CTRL_RESET[RBE_BIT_FORCE];
         sel_q <= RBE_CTRL_RESET[RBE_BIT_SEL_HI:RBE_BIT_SEL_LO];
         go_q <= RBE_CTRL_RESET[RBE_BIT_GO];
         pass_q <= RBE_CTRL_RESET[RBE_BIT_PASS];
         fail_q <= RBE_CTRL_RESET[RBE_BIT_FAIL];
         run_sel_q <= RBE_CTRL_RESET[RBE_BIT_SEL_HI:RBE_BIT_SEL_LO];
         st_q <= RBE_ST_IDLE;
         ph_q <= RBE_PH_DONE;
         step_q <= RBE_STEP_FIRST;
         addr_q <= RBE_ADDR_FIRST;
         fail_addr_q <= RBE_FAIL_ADDR_RESET;
         req_q <= '0;
      end else begin
         tp_s1_q <= tp_s1_d;
         tp_s2_q <= tp_s2_d;
         fwe_q <= fwe_d;
         force_q <= force_d;
         sel_q <= sel_d;
         go_q <= go_d;
         pass_q <= pass_d;
         fail_q <= fail_d;
         run_sel_q <= run_sel_d;
         st_q <= st_d;
         ph_q <= ph_d;
         step_q <= step_d;
         addr_q <= addr_d;
         fail_addr_q <= fail_addr_d;
         req_q <= req_d;
      end
   end

   assign reg_rdata = {fwe_q, force_q, sel_q, go_q, pass_q, fail_q, RBE_UNUSED_READ};
   assign ram_req = req_q;
   assign fail_addr = fail_addr_q;
   assign full_ram_write_enable = fwe_q;
   // host RAM path held off during a run
   assign host_block = (st_q != RBE_ST_IDLE);
endmodule

// file: hdl/rbe_lane.sv
// Expected data for the four RAM quadrants and read-back comparison
`timescale 1ns/1ps
module rbe_lane import rbe_pkg::*; (
   input wire rbe_kind_type kind,
   input wire logic [15:0] data,
   input wire logic [12:0] addr,
   input wire logic [63:0] rdata,
   output logic [63:0] expect_data,
   output logic mismatch
);
   genvar q;
   generate
      for (q = 0; q < RBE_QN; q++) begin : g_quad
         logic [15:0] full_addr;
         assign full_addr = {1'b0, 2'(q), addr};
         assign expect_data[q*16 +: 16] = (kind == RBE_K_CONST) ? data :
                                          (kind == RBE_K_ADDR) ? full_addr : ~full_addr;
      end
   endgenerate

   // Quadrants are checked together, so a mismatch names only the low-quadrant address
   assign mismatch = |(rdata ^ expect_data);
endmodule

// file: hdl/rbe_pkg.sv
// Constants, types and carriers shared by the RAM self-test engine
package rbe_pkg;
   localparam int RBE_DW = 16;
   localparam int RBE_AW = 13;
   localparam int RBE_QN = 4;
   localparam int RBE_BIT_FWE = 15;
   localparam int RBE_BIT_FORCE = 14;
   localparam int RBE_BIT_SEL_HI = 13;
   localparam int RBE_BIT_SEL_LO = 11;
   localparam int RBE_BIT_GO = 10;
   localparam int RBE_BIT_PASS = 9;
   localparam int RBE_BIT_FAIL = 8;
   localparam logic [15:0] RBE_CTRL_RESET = 16'h0000;
   localparam logic [15:0] RBE_FAIL_ADDR_RESET = 16'h0000;
   localparam logic [7:0] RBE_UNUSED_READ = 8'h00;
   localparam logic [12:0] RBE_ADDR_FIRST = 13'h0000;
   localparam logic [12:0] RBE_ADDR_LAST = 13'h1fff;
   localparam logic [12:0] RBE_HIDDEN_TOP = 13'h001f;
   localparam logic [3:0] RBE_STEP_FIRST = 4'h0;
   localparam logic [3:0] RBE_MARCH_LAST_STEP = 4'ha;
   localparam logic [15:0] RBE_ZERO = 16'h0000;
   localparam logic [15:0] RBE_ONES = 16'hffff;
   localparam logic [15:0] RBE_PAT_UP [0:4] = '{16'h5555, 16'h3333, 16'h0f0f, 16'h00ff, 16'hffff};
   localparam logic [15:0] RBE_PAT_DN [0:4] = '{16'haaaa, 16'hcccc, 16'hf0f0, 16'hff00, 16'h0000};
   localparam logic [2:0] RBE_SEL_PATTERN = 3'h1;
   localparam logic [2:0] RBE_SEL_FILL0 = 3'h2;
   localparam logic [2:0] RBE_SEL_VER0 = 3'h3;
   localparam logic [2:0] RBE_SEL_FILL1 = 3'h4;
   localparam logic [2:0] RBE_SEL_VER1 = 3'h5;
   localparam logic [2:0] RBE_SEL_INCDEC = 3'h6;

   typedef enum logic [1:0] {RBE_K_CONST, RBE_K_ADDR, RBE_K_CPL} rbe_kind_type;

   typedef enum logic [3:0] {
      RBE_PH_FILL0, RBE_PH_MARCH_UP, RBE_PH_MARCH_DN, RBE_PH_AWR, RBE_PH_ARD,
      RBE_PH_CWR, RBE_PH_CRD, RBE_PH_FILL1, RBE_PH_VER0, RBE_PH_VER1, RBE_PH_DONE
   } rbe_phase_type;

   typedef enum logic [1:0] {RBE_ST_IDLE, RBE_ST_OP, RBE_ST_WAIT, RBE_ST_CHK} rbe_state_type;

   typedef struct packed {
      logic rd;
      rbe_kind_type kind;
      logic [15:0] data;
      logic last;
   } rbe_op_type;

   typedef struct packed {
      logic [12:0] addr;
      logic hidden;
      logic we;
      logic re;
      logic [63:0] wdata;
   } rbe_ram_req_type;
endpackage

// file: verif/rbe_engine_monitor.sv
// Port assertions for the RAM self-test engine
`timescale 1ns/1ps
module rbe_engine_monitor import rbe_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic test_pin,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire rbe_ram_req_type ram_req,
   input wire logic [63:0] ram_rdata,
   input wire logic [15:0] fail_addr,
   input wire logic full_ram_write_enable,
   input wire logic host_block
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   logic [2:0] run_sel_q;
   // Running select comes from the accepted write; later writes move only the register copy
   always_ff @(posedge sys_clk) begin
      if (reg_wr && !host_block) begin
         run_sel_q <= reg_wdata[13:11];
      end
   end
   a_fwe_mirror:
      assert property (full_ram_write_enable == reg_rdata[15])
      else $error("enable output differs");
   a_go_needs_enable:
      assert property (reg_wr && !reg_rdata[15] && !host_block |=> !reg_rdata[10])
      else $error("go without enable");
   // Three low samples cover the two-stage pin synchroniser
   a_go_needs_pin:
      assert property (!test_pin [*3] ##0 (reg_wr && !host_block) |=> !host_block)
      else $error("go without pin");
   a_go_starts:
      assert property (test_pin [*3] ##0 (reg_wr && reg_wdata[10] && reg_rdata[15]
         && !host_block) |=> host_block && reg_rdata[10] && reg_rdata[9:8] == 2'h0)
      else $error("start lost");
   a_end_status:
      assert property ($fell(host_block) |-> !reg_rdata[10] && reg_rdata[9] != reg_rdata[8])
      else $error("bad end status");
   a_block_is_go:
      assert property (host_block == reg_rdata[10])
      else $error("block and go differ");
   a_quiet_idle:
      assert property (!host_block && !$past(host_block) |-> !ram_req.we && !ram_req.re)
      else $error("ram access while idle");
   a_hidden_words:
      assert property (ram_req.we || ram_req.re |-> ram_req.hidden == (ram_req.addr <= 13'h1f))
      else $error("hidden flag wrong");
   a_status_kept:
      assert property (!host_block && !reg_wr |=> $stable(reg_rdata[9:8]) && $stable(fail_addr))
      else $error("status moved while idle");
   a_fill_data:
      assert property (ram_req.we && host_block && run_sel_q inside {3'h2, 3'h4}
         |-> ram_req.wdata == {64{run_sel_q[2]}})
      else $error("fill data wrong");
   a_read_gap:
      assert property (ram_req.re |=> !ram_req.re)
      else $error("reads too close");
   c_pass: cover property ($fell(host_block) && reg_rdata[9]);
   c_fail: cover property ($fell(host_block) && reg_rdata[8]);
   c_refused: cover property (reg_wr && reg_wdata[10] && !reg_rdata[15]);
endmodule
bind rbe_engine rbe_engine_monitor i_mon (.sys_clk(sys_clk), .rstn(rstn), .test_pin(test_pin),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_req(ram_req),
   .ram_rdata(ram_rdata), .fail_addr(fail_addr),
   .full_ram_write_enable(full_ram_write_enable), .host_block(host_block));

// file: verif/rbe_engine_tb.sv
// Self-checking bench for the RAM self-test engine
`timescale 1ns/1ps
module rbe_engine_tb import rbe_pkg::*; ;
   logic sys_clk, rstn, test_pin, reg_wr, fwe, host_block, flt_en;
   logic [15:0] reg_wdata, reg_rdata, fail_addr, flt_v;
   logic [63:0] ram_rdata;
   logic [63:0] mem [0:8191];
   logic [12:0] flt_a;
   rbe_ram_req_type ram_req;
   int err_total = 0;
   int num_checks = 0;
   rbe_engine i_dut (.sys_clk(sys_clk), .rstn(rstn), .test_pin(test_pin), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata),
      .fail_addr(fail_addr), .full_ram_write_enable(fwe), .host_block(host_block));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Four-quadrant RAM; a planted fault flips a quadrant 3 bit on every matching read
   always @(posedge sys_clk) begin
      if (ram_req.we) mem[ram_req.addr] <= ram_req.wdata;
      if (ram_req.re) ram_rdata <= mem[ram_req.addr] ^ ((flt_en && ram_req.addr == flt_a
         && mem[ram_req.addr][15:0] == flt_v) ? 64'h8000_0000_0000_0000 : 64'h0);
   end
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic final_report();
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Strobe drops two cycles before the next write so it is never driven twice at one edge
   task automatic wr(input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic plant(input logic [12:0] a, input logic [15:0] v);
      flt_en <= 1'b1;
      flt_a <= a;
      flt_v <= v;
   endtask
   task automatic run(input logic [15:0] d, input logic [1:0] st, input logic [15:0] fa);
      int n;
      n = 0;
      wr(d);
      while (host_block !== 1'b0 && n < 50000) begin
         @(posedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      chk("run ends", 1'b1, n < 50000);
      chk("control", {d[15:11], 1'b0, st, 8'h00}, reg_rdata);
      chk("fail_addr", fa, fail_addr);
   endtask
   initial begin
      rstn = 1'b0;
      test_pin = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      flt_en = 1'b0;
      flt_a = 13'h0000;
      flt_v = 16'h0000;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk("reset control", 16'h0000, reg_rdata);
      wr(16'h8400);
      chk("go refused", 16'h8000, reg_rdata);
      wr(16'h8400);
      chk("go refused", 16'h8000, reg_rdata);
      chk("enable out", 1'b1, fwe);
      test_pin <= 1'b1;
      wr(16'h0000);
      wr(16'h8400);
      chk("go refused", 16'h8000, reg_rdata);
      run(16'h8400, 2'b10, 16'h0000);
      run(16'hbc00, 2'b10, 16'h0000);
      run(16'h9400, 2'b10, 16'h0000);
      chk("fill zeros", 64'h0, mem[13'h1fff]);
      run(16'hdc00, 2'b01, 16'h0000);
      run(16'ha400, 2'b10, 16'h0000);
      chk("fill ones", 64'hffff_ffff_ffff_ffff, mem[13'h0abc]);
      plant(13'h0123, 16'hffff);
      run(16'hac00, 2'b01, 16'h0123);
      plant(13'h0005, 16'h3333);
      run(16'h8c00, 2'b01, 16'h0005);
      chk("march done", 16'hffff, mem[13'h0004][15:0]);
      chk("march step", 16'h3333, mem[13'h0005][15:0]);
      chk("march ahead", 64'h0, mem[13'h0006]);
      plant(13'h0010, 16'h0010);
      run(16'hb400, 2'b01, 16'h0010);
      chk("address fill", 16'h1fff, mem[13'h1fff][15:0]);
      plant(13'h0010, 16'hffef);
      run(16'hb400, 2'b01, 16'h0010);
      chk("complement fill", 16'he000, mem[13'h1fff][15:0]);
      final_report();
   end
   // Tests need about 75000 cycles in total
   initial begin
      repeat (95000) @(posedge sys_clk);
      err_total++;
      final_report();
   end
endmodule
